// ===== core/lsh_pkg.sv
package lsh_pkg;

    localparam int          CH_N        = 4;
    localparam int          SENSE_W     = 8;
    localparam int          LONG_W      = 9;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 16;
    localparam int          PRE_W       = 13;

    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DEB_STEP_NS   = 125000;
    localparam int unsigned DEB_STEP_CYC  = DEB_STEP_NS / CLK_PERIOD_NS;

    // sense words: one code is 100 uA
    localparam int unsigned SENSE_LSB_UA   = 100;
    localparam int unsigned OFF_HOOK_ROM_UA = 7000;
    localparam int unsigned HYST_ROM_UA     = 2000;
    localparam int unsigned GK_THR_UA       = 11800;
    localparam logic [SENSE_W-1:0] OFF_HOOK_ROM_CODE =
        SENSE_W'(OFF_HOOK_ROM_UA / SENSE_LSB_UA);
    localparam logic [SENSE_W-1:0] HYST_ROM_CODE =
        SENSE_W'(HYST_ROM_UA / SENSE_LSB_UA);
    localparam logic [LONG_W-1:0]  GK_THR_CODE =
        LONG_W'(GK_THR_UA / SENSE_LSB_UA);

    // register offsets
    localparam logic [ADDR_W-1:0] ADR_HOOK_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADR_LONG_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADR_SIG_CFG     = 4'h2;
    localparam logic [ADDR_W-1:0] ADR_THR_WORD    = 4'h3;
    localparam logic [ADDR_W-1:0] ADR_HYST_WORD   = 4'h4;
    localparam logic [ADDR_W-1:0] ADR_DEB_CFG     = 4'h5;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK    = 4'h6;
    localparam logic [ADDR_W-1:0] ADR_LINE_CTL    = 4'h7;
    localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS  = 4'h8;
    localparam logic [ADDR_W-1:0] ADR_IRQ_ENABLE  = 4'h9;
    localparam logic [ADDR_W-1:0] ADR_IRQ_CLEAR   = 4'ha;

    // field positions
    localparam int SRC_BIT      = 0;
    localparam int REV_BIT      = 0;
    localparam int RAMP_PER_LSB = 8;
    localparam int MASK_HK      = 0;
    localparam int MASK_GK      = 1;
    localparam int MASK_POL     = 2;
    localparam int IRQ_HK_LSB   = 0;
    localparam int IRQ_GK_LSB   = 4;
    localparam int IRQ_POL_LSB  = 8;
    localparam int IRQ_W        = 12;

    // reset values
    localparam logic       SRC_RST      = 1'b1;
    localparam logic [3:0] DEB_RST      = 4'h0;
    localparam logic [2:0] MASK_RST     = 3'h0;
    localparam logic [7:0] RAMP_PER_RST = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } lsh_bus_req_s;

    typedef struct packed {
        logic [CH_N-1:0][SENSE_W-1:0] tdc;
        logic [CH_N-1:0][LONG_W-1:0]  vl;
    } lsh_sense_s;

    typedef struct packed {
        logic [CH_N-1:0][SENSE_W-1:0] tdc_s1;
        logic [CH_N-1:0][SENSE_W-1:0] tdc_s2;
        logic [CH_N-1:0][LONG_W-1:0]  vl_s1;
        logic [CH_N-1:0][LONG_W-1:0]  vl_s2;
        logic [PRE_W-1:0]             pre_cnt;
        logic [3:0]                   int_cnt;
        logic [CH_N-1:0][3:0]         hk_cnt;
        logic [CH_N-1:0][3:0]         gk_cnt;
        logic [CH_N-1:0][3:0]         pl_cnt;
        logic [CH_N-1:0]              hook;
        logic [CH_N-1:0]              gkey;
        logic [CH_N-1:0]              pol;
        logic                         src;
        logic [SENSE_W-1:0]           thr;
        logic [SENSE_W-1:0]           hyst;
        logic [3:0]                   db;
        logic [2:0]                   mask;
        logic                         rev;
        logic [7:0]                   ramp_per;
        logic [7:0]                   ramp_cnt;
        logic [7:0]                   ramp_pos;
        logic [IRQ_W-1:0]             irq_st;
        logic [IRQ_W-1:0]             irq_en;
        logic                         irq;
        logic [DATA_W-1:0]            rdata;
    } lsh_state_s;

endpackage : lsh_pkg

// ===== core/lsh_loop_supervision.sv
// Contract
// - four off-hook flags, 0 on-hook, 1 off-hook
// - off-hook flag changes interrupt while hook mask is 0, none when 1
// - source bit picks programmed (0) or rom (1) threshold; resets to 1
// - off-hook threshold programmable 0..20 mA, rom value 7 mA
// - hysteresis programmable 0..20 mA, rom value 2 mA
// - four-bit debounce interval, 0.125 ms steps to 2 ms, resets to 0
// - ground key set when longitudinal current exceeds fixed 11.8 mA
// - four ground-key flags, 1 while longitudinal current is detected
// - ground-key flag rising from 0 to 1 raises an interrupt
// - ground-key mask 0 lets those interrupts through, 1 suppresses them
// - polarity flag 0 for negative, 1 for positive longitudinal level
// - every polarity flag change interrupts unless polarity mask is 1
// - ground-key criterion uses the same debounce filter as off-hook
// - writing 1 to the reverse bit reverses tip/ring polarity
// - reversal is ramped, its pace set by a programmable ramp step period
// - off-hook flag set when filtered transversal sense exceeds threshold
// - on-hook return uses threshold minus hysteresis
// - 16-state up/down counter clocked at the debounce interval
//
// Implementation choices: the strobed register port and the register addresses.
module lsh_loop_supervision #(
    parameter int unsigned DEB_STEP_CYCLES = lsh_pkg::DEB_STEP_CYC
) (
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    input  wire lsh_pkg::lsh_bus_req_s       bus_req,
    output logic [lsh_pkg::DATA_W-1:0]       rdata,
    input  wire lsh_pkg::lsh_sense_s         sense,
    output logic                             irq,
    output logic                             line_polarity_reverse_ctl,
    output logic [7:0]                       ramp_position
);

    localparam logic [lsh_pkg::PRE_W-1:0] PRE_MAX =
        lsh_pkg::PRE_W'(DEB_STEP_CYCLES - 1);

    logic [1:0]                          rst_q;
    logic                                rst_n;
    lsh_pkg::lsh_state_s                 st;
    lsh_pkg::lsh_state_s                 next_st;
    logic [lsh_pkg::SENSE_W-1:0]         thr_eff;
    logic [lsh_pkg::SENSE_W-1:0]         hyst_eff;
    logic [lsh_pkg::SENSE_W-1:0]         on_thr;
    logic [lsh_pkg::CH_N-1:0]            hk_raw;
    logic [lsh_pkg::CH_N-1:0]            gk_raw;
    logic [lsh_pkg::CH_N-1:0]            pl_raw;
    logic                                pre_tick;
    logic                                ivl_tick;
    logic                                ramp_tick;
    logic [lsh_pkg::IRQ_W-1:0]           events;
    logic [lsh_pkg::IRQ_W-1:0]           clr;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign thr_eff  = st.src ? lsh_pkg::OFF_HOOK_ROM_CODE : st.thr;
    assign hyst_eff = st.src ? lsh_pkg::HYST_ROM_CODE : st.hyst;
    // on-hook level saturates at zero when hysteresis exceeds threshold
    assign on_thr   = (thr_eff > hyst_eff) ? thr_eff - hyst_eff : '0;

    for (genvar ch = 0; ch < lsh_pkg::CH_N; ch++) begin : g_crit
        logic [lsh_pkg::LONG_W-1:0] mag;
        assign mag = st.vl_s2[ch][lsh_pkg::LONG_W-1] ?
                     lsh_pkg::LONG_W'(-st.vl_s2[ch]) : st.vl_s2[ch];
        assign hk_raw[ch] = st.hook[ch] ? (st.tdc_s2[ch] > on_thr)
                                        : (st.tdc_s2[ch] > thr_eff);
        assign gk_raw[ch] = mag > lsh_pkg::GK_THR_CODE;
        assign pl_raw[ch] = !st.vl_s2[ch][lsh_pkg::LONG_W-1];
    end

    // saturating up/down count; flag flips only at the ends
    function automatic logic [4:0] deb_step(input logic [3:0] cnt,
                                            input logic       flag,
                                            input logic       raw);
        logic [3:0] c;
        logic       f;
        c = cnt;
        f = flag;
        if (raw && c != 4'hf) begin
            c = c + 4'h1;
        end else if (!raw && c != 4'h0) begin
            c = c - 4'h1;
        end
        if (c == 4'hf) begin
            f = 1'b1;
        end else if (c == 4'h0) begin
            f = 1'b0;
        end
        return {c, f};
    endfunction : deb_step

    always_comb begin
        next_st = st;
        next_st.tdc_s1 = sense.tdc;
        next_st.tdc_s2 = st.tdc_s1;
        next_st.vl_s1  = sense.vl;
        next_st.vl_s2  = st.vl_s1;

        pre_tick  = (st.pre_cnt >= PRE_MAX);
        ivl_tick  = pre_tick && (st.int_cnt >= st.db);
        ramp_tick = pre_tick && (st.ramp_cnt >= st.ramp_per);
        next_st.pre_cnt = pre_tick ? '0 : st.pre_cnt + 1'b1;
        if (pre_tick) begin
            next_st.int_cnt  = ivl_tick ? 4'h0 : st.int_cnt + 4'h1;
            next_st.ramp_cnt = ramp_tick ? 8'h00 : st.ramp_cnt + 8'h01;
        end

        if (ivl_tick) begin
            for (int ch = 0; ch < lsh_pkg::CH_N; ch++) begin
                {next_st.hk_cnt[ch], next_st.hook[ch]} =
                    deb_step(st.hk_cnt[ch], st.hook[ch], hk_raw[ch]);
                {next_st.gk_cnt[ch], next_st.gkey[ch]} =
                    deb_step(st.gk_cnt[ch], st.gkey[ch], gk_raw[ch]);
                {next_st.pl_cnt[ch], next_st.pol[ch]} =
                    deb_step(st.pl_cnt[ch], st.pol[ch], pl_raw[ch]);
            end
        end

        events = '0;
        events[lsh_pkg::IRQ_HK_LSB +: lsh_pkg::CH_N] =
            (next_st.hook ^ st.hook) & {lsh_pkg::CH_N{!st.mask[lsh_pkg::MASK_HK]}};
        events[lsh_pkg::IRQ_GK_LSB +: lsh_pkg::CH_N] =
            (next_st.gkey & ~st.gkey) & {lsh_pkg::CH_N{!st.mask[lsh_pkg::MASK_GK]}};
        events[lsh_pkg::IRQ_POL_LSB +: lsh_pkg::CH_N] =
            (next_st.pol ^ st.pol) & {lsh_pkg::CH_N{!st.mask[lsh_pkg::MASK_POL]}};

        clr = '0;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                lsh_pkg::ADR_SIG_CFG:    next_st.src  = bus_req.wdata[lsh_pkg::SRC_BIT];
                lsh_pkg::ADR_THR_WORD:   next_st.thr  = bus_req.wdata[7:0];
                lsh_pkg::ADR_HYST_WORD:  next_st.hyst = bus_req.wdata[7:0];
                lsh_pkg::ADR_DEB_CFG:    next_st.db   = bus_req.wdata[3:0];
                lsh_pkg::ADR_IRQ_MASK:   next_st.mask = bus_req.wdata[2:0];
                lsh_pkg::ADR_LINE_CTL: begin
                    next_st.rev      = bus_req.wdata[lsh_pkg::REV_BIT];
                    next_st.ramp_per = bus_req.wdata[lsh_pkg::RAMP_PER_LSB +: 8];
                end
                lsh_pkg::ADR_IRQ_ENABLE: next_st.irq_en = bus_req.wdata[11:0];
                lsh_pkg::ADR_IRQ_CLEAR:  clr = bus_req.wdata[11:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_st.irq_st = (st.irq_st & ~clr) | events;
        next_st.irq    = |(next_st.irq_st & next_st.irq_en);

        // ramp walks one code per step toward the requested polarity
        if (ramp_tick) begin
            if (st.rev && st.ramp_pos != 8'hff) begin
                next_st.ramp_pos = st.ramp_pos + 8'h01;
            end else if (!st.rev && st.ramp_pos != 8'h00) begin
                next_st.ramp_pos = st.ramp_pos - 8'h01;
            end
        end

        next_st.rdata = '0;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                lsh_pkg::ADR_HOOK_STATUS: next_st.rdata[7:0] = {st.gkey, st.hook};
                lsh_pkg::ADR_LONG_STATUS: next_st.rdata[3:0] = st.pol;
                lsh_pkg::ADR_SIG_CFG:     next_st.rdata[0]   = st.src;
                lsh_pkg::ADR_THR_WORD:    next_st.rdata[7:0] = st.thr;
                lsh_pkg::ADR_HYST_WORD:   next_st.rdata[7:0] = st.hyst;
                lsh_pkg::ADR_DEB_CFG:     next_st.rdata[3:0] = st.db;
                lsh_pkg::ADR_IRQ_MASK:    next_st.rdata[2:0] = st.mask;
                lsh_pkg::ADR_LINE_CTL:    next_st.rdata = {st.ramp_per, 7'h00, st.rev};
                lsh_pkg::ADR_IRQ_STATUS:  next_st.rdata[11:0] = st.irq_st;
                lsh_pkg::ADR_IRQ_ENABLE:  next_st.rdata[11:0] = st.irq_en;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.src      <= lsh_pkg::SRC_RST;
            st.db       <= lsh_pkg::DEB_RST;
            st.mask     <= lsh_pkg::MASK_RST;
            st.ramp_per <= lsh_pkg::RAMP_PER_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata                     = st.rdata;
    assign irq                       = st.irq;
    assign line_polarity_reverse_ctl = st.rev;
    assign ramp_position             = st.ramp_pos;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_RESET_DEFAULTS: assert property (
        $rose(rst_n) |-> st.src && st.db == 4'h0 && st.irq == 1'b0)
        else $error("reset defaults wrong");

    AST_ROM_LEVELS: assert property (
        st.src |-> thr_eff == 8'h46 && hyst_eff == 8'h14)
        else $error("rom threshold or hysteresis wrong");

    AST_PROG_LEVELS: assert property (
        !st.src |-> thr_eff == st.thr && hyst_eff == st.hyst)
        else $error("programmed levels not used");

    AST_HOOK_SET: assert property (
        $rose(st.hook[0]) |-> $past(hk_raw[0]) && $past(ivl_tick))
        else $error("off-hook set without criterion");

    AST_HOOK_CLEAR: assert property (
        $fell(st.hook[0]) |-> !$past(st.tdc_s2[0] > on_thr))
        else $error("on-hook set above on-hook level");

    AST_HOOK_MASKED: assert property (
        st.mask[0] && st.irq_st[3:0] == 4'h0 |=> st.irq_st[3:0] == 4'h0)
        else $error("masked off-hook change interrupted");

    AST_HOOK_IRQ: assert property (
        $changed(st.hook) && !$past(st.mask[0]) |-> st.irq_st[3:0] != 4'h0)
        else $error("off-hook change lost");

    AST_GK_IRQ: assert property (
        $rose(st.gkey[0]) && !$past(st.mask[1]) |-> st.irq_st[4])
        else $error("ground-key rise lost");

    AST_GK_SET: assert property (
        $rose(st.gkey[0]) |-> $past(gk_raw[0]) && $past(st.gk_cnt[0]) == 4'he)
        else $error("ground key set before debounce");

    AST_POL_IRQ: assert property (
        $changed(st.pol[0]) && !$past(st.mask[2]) |-> st.irq_st[8])
        else $error("polarity change lost");

    AST_IRQ_OUT: assert property (
        ##1 st.irq == |(st.irq_st & st.irq_en))
        else $error("interrupt output mismatch");

    AST_RAMP: assert property (
        $changed(st.ramp_pos) |-> (st.ramp_pos == $past(st.ramp_pos) + 8'h01)
                                  == $past(st.rev))
        else $error("ramp moved the wrong way");

    AST_SRC_WRITE: assert property (
        $past(bus_req.wr) && $past(bus_req.addr) == lsh_pkg::ADR_SIG_CFG
        |-> st.src == $past(bus_req.wdata[lsh_pkg::SRC_BIT]))
        else $error("source select write lost");

    AST_PRE_BOUND: assert property (
        st.pre_cnt <= PRE_MAX)
        else $error("prescaler ran past its end");

    AST_RDATA_IDLE: assert property (
        !$past(bus_req.rd) |-> st.rdata == 16'h0000)
        else $error("read data outside read cycle");

    AST_SET_WINS: assert property (
        (st.irq_st & $past(events)) == $past(events))
        else $error("status event lost to a clear");

    AST_CLEAR_W1C: assert property (
        $past(bus_req.wr) && $past(bus_req.addr) == lsh_pkg::ADR_IRQ_CLEAR
        |-> (st.irq_st & $past(bus_req.wdata[11:0] & ~events)) == 12'h000)
        else $error("status bit survived its clear");

    AST_EN_WRITE: assert property (
        $past(bus_req.wr) && $past(bus_req.addr) == lsh_pkg::ADR_IRQ_ENABLE
        |-> st.irq_en == $past(bus_req.wdata[11:0]))
        else $error("enable write lost");

    AST_REV_WRITE: assert property (
        $past(bus_req.wr) && $past(bus_req.addr) == lsh_pkg::ADR_LINE_CTL
        |-> st.rev == $past(bus_req.wdata[lsh_pkg::REV_BIT]))
        else $error("reverse bit write lost");

    AST_RAMP_STEP: assert property (
        $changed(st.ramp_pos) |-> $past(ramp_tick))
        else $error("ramp moved between steps");

    AST_RAMP_END: assert property (
        st.rev && st.ramp_pos == 8'hff |=> st.ramp_pos == 8'hff)
        else $error("ramp left its reversed end");

    // per-channel synchroniser, filter and event checks
    for (genvar ch = 0; ch < lsh_pkg::CH_N; ch++) begin : g_chk
        AST_HK_TICK: assert property (
            $changed(st.hook[ch]) |-> $past(ivl_tick))
            else $error("off-hook flag moved between ticks");

        AST_HK_STEP: assert property (
            !$past(ivl_tick) |-> $stable(st.hk_cnt[ch]))
            else $error("off-hook counter moved between ticks");

        AST_HK_ENDS: assert property (
            st.hk_cnt[ch] == 4'hf |-> st.hook[ch])
            else $error("off-hook counter full, flag low");

        AST_HK_RISE: assert property (
            $rose(st.hook[ch]) |-> $past(st.tdc_s2[ch] > thr_eff))
            else $error("off-hook set below threshold");

        AST_HK_FALL: assert property (
            $fell(st.hook[ch]) |-> !$past(st.tdc_s2[ch] > on_thr))
            else $error("on-hook set above on-hook level");

        AST_HK_IRQ: assert property (
            $changed(st.hook[ch]) && !$past(st.mask[0]) |-> st.irq_st[ch])
            else $error("off-hook change lost");

        AST_HK_MASKED: assert property (
            $changed(st.hook[ch]) && $past(st.mask[0])
            && !$past(st.irq_st[ch]) |-> !st.irq_st[ch])
            else $error("masked off-hook change interrupted");

        AST_GK_TICK: assert property (
            $changed(st.gkey[ch]) |-> $past(ivl_tick))
            else $error("ground-key flag moved between ticks");

        AST_GK_STEP: assert property (
            !$past(ivl_tick) |-> $stable(st.gk_cnt[ch]))
            else $error("ground-key counter moved between ticks");

        AST_GK_ENDS: assert property (
            st.gk_cnt[ch] == 4'hf |-> st.gkey[ch])
            else $error("ground-key counter full, flag low");

        AST_GK_RISE: assert property (
            $rose(st.gkey[ch]) |-> $past(gk_raw[ch]))
            else $error("ground key set without criterion");

        AST_GK_IRQ_CH: assert property (
            $rose(st.gkey[ch]) && !$past(st.mask[1]) |-> st.irq_st[4 + ch])
            else $error("ground-key rise lost");

        AST_GK_FALL: assert property (
            $fell(st.gkey[ch]) && !$past(st.irq_st[4 + ch])
            |-> !st.irq_st[4 + ch])
            else $error("ground-key fall interrupted");

        AST_GK_MASKED: assert property (
            $rose(st.gkey[ch]) && $past(st.mask[1])
            && !$past(st.irq_st[4 + ch]) |-> !st.irq_st[4 + ch])
            else $error("masked ground-key rise interrupted");

        AST_PL_TICK: assert property (
            $changed(st.pol[ch]) |-> $past(ivl_tick))
            else $error("polarity flag moved between ticks");

        AST_PL_STEP: assert property (
            !$past(ivl_tick) |-> $stable(st.pl_cnt[ch]))
            else $error("polarity counter moved between ticks");

        AST_PL_RISE: assert property (
            $rose(st.pol[ch]) |-> !$past(st.vl_s2[ch][lsh_pkg::LONG_W-1]))
            else $error("positive polarity on negative level");

        AST_PL_FALL: assert property (
            $fell(st.pol[ch]) |-> $past(st.vl_s2[ch][lsh_pkg::LONG_W-1]))
            else $error("negative polarity on positive level");

        AST_PL_MASKED: assert property (
            $changed(st.pol[ch]) && $past(st.mask[2])
            && !$past(st.irq_st[8 + ch]) |-> !st.irq_st[8 + ch])
            else $error("masked polarity change interrupted");

        AST_SYNC: assert property (
            st.tdc_s2[ch] == $past(st.tdc_s1[ch]))
            else $error("sense synchroniser skipped a stage");
    end

    COV_HOOK_RISE: cover property ($rose(st.hook[0]));
    COV_HOOK_FALL: cover property ($fell(st.hook[0]));
    COV_GK_RISE:   cover property ($rose(st.gkey[1]));
    COV_POL_CHG:   cover property ($changed(st.pol[2]));
    COV_IRQ:       cover property ($rose(st.irq));

endmodule : lsh_loop_supervision

// ===== tb/lsh_line_model.sv
module lsh_line_model #(
    parameter int unsigned LAG = 2
) (
    input  wire logic           core_clk,
    output lsh_pkg::lsh_sense_s sense
);
    timeunit 1ns;
    timeprecision 1ps;

    lsh_pkg::lsh_sense_s target   = '0;
    int unsigned         wait_cnt = 0;

    initial sense = '0;

    // a new loop state reaches the pins LAG+1 cycles late, whole words at once
    always @(posedge core_clk) begin
        if (sense != target && wait_cnt >= LAG) begin
            sense    <= target;
            wait_cnt <= 0;
        end else if (sense != target) begin
            wait_cnt <= wait_cnt + 1;
        end
    end

    task set_loop(input int ch, input logic [7:0] code);
        target.tdc[ch] = code;
    endtask : set_loop

    task set_long(input int ch, input logic [8:0] code);
        target.vl[ch] = code;
    endtask : set_long

endmodule : lsh_line_model

// ===== tb/tb_loop_supervision_hook_groundkey.sv
module tb_loop_supervision_hook_groundkey;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned P = 4;

    logic                  core_clk    = 1'b0;
    logic                  resetn      = 1'b0;
    lsh_pkg::lsh_bus_req_s bus_req     = '0;
    lsh_pkg::lsh_sense_s   sense;
    logic [15:0]           rdata;
    logic                  irq;
    logic                  line_polarity_reverse_ctl;
    logic [7:0]            ramp_position;
    logic [16:0]           expq[$];
    logic                  rd_seen     = 1'b0;
    logic [31:0]           seed        = 32'd49904;
    int                    n_errors    = 0;
    int                    checks_done = 0;

    always #12.5 core_clk = ~core_clk;

    lsh_loop_supervision #(.DEB_STEP_CYCLES(P)) dut (
        .core_clk                  (core_clk),
        .resetn                    (resetn),
        .bus_req                   (bus_req),
        .rdata                     (rdata),
        .sense                     (sense),
        .irq                       (irq),
        .line_polarity_reverse_ctl (line_polarity_reverse_ctl),
        .ramp_position             (ramp_position)
    );

    lsh_line_model #(.LAG(2)) line (
        .core_clk (core_clk),
        .sense    (sense)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task results();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // wait long enough for 15 interval ticks plus sync and model lag
    task settle(input int db);
        cyc(18 * P * (db + 1) + 12);
    endtask : settle

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // expected word is {irq, rdata} in the cycle after the read strobe
    task rd(input logic [3:0] a, input logic [16:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        expq.push_back(exp);
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
    endtask : rd

    task wait_ramp(input logic [7:0] v);
        for (int i = 0; i < 300 * P && ramp_position !== v; i++)
            @(posedge core_clk);
        check({24'h0, ramp_position}, {24'h0, v});
        if (ramp_position !== v)
            results();
    endtask : wait_ramp

    always @(posedge core_clk) begin
        if (rd_seen && expq.size() > 0)
            check({15'h0, irq, rdata}, {15'h0, expq.pop_front()});
        rd_seen <= bus_req.rd;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(4);
        rd(lsh_pkg::ADR_SIG_CFG, 17'h00001);
        rd(lsh_pkg::ADR_DEB_CFG, 17'h00000);
        rd(lsh_pkg::ADR_IRQ_MASK, 17'h00000);
        rd(4'hf, 17'h00000);
        wr(lsh_pkg::ADR_IRQ_ENABLE, 16'h0fff);
        line.set_loop(0, 8'd71);
        line.set_loop(1, 8'd70);
        line.set_loop(2, 8'(xs() % 31));
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h10001);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h10f01);
        rd(lsh_pkg::ADR_LONG_STATUS, 17'h1000f);
        wr(lsh_pkg::ADR_IRQ_CLEAR, 16'h0fff);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h00000);
        line.set_loop(0, 8'd51);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00001);
        line.set_loop(0, 8'd50);
        settle(0);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h10001);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h10000);
        wr(lsh_pkg::ADR_IRQ_CLEAR, 16'h0fff);
        $display("test rom threshold done");

        line.set_loop(0, 8'd0);
        line.set_loop(1, 8'd0);
        wr(lsh_pkg::ADR_THR_WORD, 16'd30);
        wr(lsh_pkg::ADR_HYST_WORD, 16'd5);
        wr(lsh_pkg::ADR_SIG_CFG, 16'h0000);
        line.set_loop(2, 8'd31);
        settle(0);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h10004);
        wr(lsh_pkg::ADR_IRQ_CLEAR, 16'h0fff);
        line.set_loop(2, 8'd26);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00004);
        wr(lsh_pkg::ADR_IRQ_MASK, 16'h0001);
        line.set_loop(2, 8'd25);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00000);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h00000);
        $display("test programmed threshold done");

        wr(lsh_pkg::ADR_IRQ_MASK, 16'h0000);
        line.set_long(1, 9'd118);
        line.set_long(3, 9'h189);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h10080);
        rd(lsh_pkg::ADR_LONG_STATUS, 17'h10007);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h10880);
        wr(lsh_pkg::ADR_IRQ_CLEAR, 16'h0fff);
        line.set_long(3, 9'd0);
        settle(0);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h10800);
        wr(lsh_pkg::ADR_IRQ_CLEAR, 16'h0fff);
        wr(lsh_pkg::ADR_IRQ_MASK, 16'h0006);
        line.set_long(3, 9'h189);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00080);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h00000);
        line.set_long(3, 9'd0);
        settle(0);
        wr(lsh_pkg::ADR_IRQ_MASK, 16'h0000);
        line.set_long(0, 9'd200);
        cyc(8 * P);
        line.set_long(0, 9'd0);
        settle(0);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00000);
        rd(lsh_pkg::ADR_IRQ_STATUS, 17'h00000);
        $display("test ground key done");

        wr(lsh_pkg::ADR_DEB_CFG, 16'h0001);
        rd(lsh_pkg::ADR_DEB_CFG, 17'h00001);
        line.set_loop(1, 8'd100);
        cyc(15 * P + 8);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h00000);
        settle(1);
        rd(lsh_pkg::ADR_HOOK_STATUS, 17'h10002);
        $display("test debounce interval done");

        wr(lsh_pkg::ADR_LINE_CTL, 16'h0001);
        cyc(4);
        check({31'h0, line_polarity_reverse_ctl}, 32'h1);
        check({31'h0, ramp_position === 8'hff}, 32'h0);
        wait_ramp(8'hff);
        wr(lsh_pkg::ADR_LINE_CTL, 16'h0000);
        wait_ramp(8'h00);
        $display("test polarity reversal done");
        cyc(4);
        results();
    end

endmodule : tb_loop_supervision_hook_groundkey
